//--- design/sgc_params.svh
// register offsets, field positions and reset values of the general register bank
`ifndef SGC_PARAMS_SVH
`define SGC_PARAMS_SVH
`define SGC_OFF_GMR 8'h00
`define SGC_OFF_GSR 8'h04
`define SGC_OFF_ISR 8'h08
`define SGC_OFF_IMR 8'h0c
`define SGC_OFF_NSR 8'h10
`define SGC_OFF_NER 8'h14
`define SGC_GMR_RST 32'h00000000
`define SGC_GMR_WMASK 32'h0000030e
`define SGC_IRQ_RST 5'h00
`define SGC_ERR_RST 6'h00
`define SGC_GMR_COLD 0
`define SGC_GMR_ARB 1
`define SGC_GMR_PFD 2
`define SGC_GMR_UCS 3
`define SGC_GMR_HSW 8
`define SGC_GMR_MSW 9
`define SGC_GSR_ENDC 0
`define SGC_GSR_SPEED 1
`define SGC_GSR_CISA 2
`define SGC_ISR_TM0 0
`define SGC_ISR_TM1 1
`define SGC_ISR_UART 2
`define SGC_ISR_EXT 3
`define SGC_ISR_WU 4
`define SGC_NSR_CB 0
`define SGC_NSR_IB 1
`define SGC_NSR_IT 2
`define SGC_NSR_MA 3
`define SGC_NSR_EXT 4
`define SGC_NSR_IR 5
`endif

//--- design/sgc_pkg.sv
// types shared by the general register bank
package sgc_pkg;
  typedef enum logic [1:0] {SGC_SZ_1B, SGC_SZ_2B, SGC_SZ_3B, SGC_SZ_WORD} sgc_size_t;
  // one register access from the cpu system bus
  typedef struct packed {
    logic valid;
    logic write;
    logic burst;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } sgc_regreq_t;
  // one data phase on the cpu to on-chip master path
  typedef struct packed {
    logic [31:0] data;
    sgc_size_t size;
    logic [1:0] off;
    logic in_target;
    logic addr_swap;
  } sgc_hswap_t;
  // one data phase on the memory to on-chip slave path
  typedef struct packed {
    logic [31:0] data;
    logic via_slave;
    logic addr_swap;
  } sgc_mswap_t;
  // maskable interrupt sources, one-cycle or level
  typedef struct packed {
    logic timer0;
    logic timer1;
    logic uart_rx_full;
    logic uart_tx_empty;
    logic uart_line_stat;
    logic uart_modem_stat;
    logic usb_wakeup;
    logic eth_wakeup;
  } sgc_irq_src_t;
  // error event sources from other bus blocks
  typedef struct packed {
    logic mem_reserved;
    logic mem_out_of_range;
    logic rom_narrow;
    logic rom_burst_write;
    logic cpu_illegal_cmd;
    logic cpu_illegal_align;
    logic cpu_illegal_burst;
    logic onchip_reserved;
    logic onchip_timeout;
  } sgc_err_src_t;
endpackage

//--- design/sgc_regs.sv
// general mode, strap status, interrupt and error registers of the system controller
`timescale 1ns/1ps
`default_nettype none
`include "sgc_params.svh"
// How it works
// RULE1 - mode register, zero reset, reserved bits zero
// RULE2 - arbiter disabled grants only controller itself
// RULE3 - software enables arbiter after initialisation
// RULE4 - writing one to bit0 starts cold reset
// RULE5 - bit2 disables the prefetch buffer
// RULE6 - bit3 picks external or half cpu clock
// RULE7 - bit8 enables master swap in swap mode
// RULE8 - byte reverses lanes, halfword swaps halves
// RULE9 - three byte accesses rotate, disabled passes through
// RULE10 - bit9 reverses memory slave path bytes
// RULE11 - status bit1 shows captured cpu speed strap
// RULE12 - status bits0,2 show other captured straps
// RULE13 - pending bits clear on read, events re-set
// RULE14 - pending bit layout, upper bits zero
// RULE15 - any of four uart causes sets uart
// RULE16 - clear only when lowest byte is read
// RULE17 - wakeup pending is or of two requests
// RULE18 - wakeup reaches core as cause bit 6
// RULE19 - interrupt when pending and unmask both set
// RULE20 - error pending bit layout
// RULE21 - four memory faults set address error
// RULE22 - cpu and on-chip bus error causes
// RULE23 - error pending clears on lowest byte read
// RULE24 - nmi when error pending and enabled
// RULE25 - interrupt is level until clearing read
module sgc_regs #(
  parameter int NREQ = 4
) (
  input wire logic clock,
  input wire logic srst,
  input wire sgc_pkg::sgc_regreq_t reg_req,
  output logic reg_ack,
  output logic [31:0] reg_rdata,
  output logic reg_data_err,
  input wire sgc_pkg::sgc_hswap_t hsw_in,
  output logic [31:0] hsw_out,
  input wire sgc_pkg::sgc_mswap_t msw_in,
  output logic [31:0] msw_out,
  input wire logic [NREQ-1:0] bus_req,
  output logic [NREQ-1:0] bus_grant,
  output logic prefetch_disable,
  output logic uart_clock_source_sel,
  output logic cold_reset_request,
  input wire logic endian_conv_strap,
  input wire logic cpu_speed_strap,
  input wire logic compressed_isa_strap,
  input wire sgc_pkg::sgc_irq_src_t irq_src,
  input wire logic ext_irq_pin_n,
  input wire logic ext_nonmaskable_pin_n,
  input wire sgc_pkg::sgc_err_src_t err_src,
  output logic cpu_int,
  output logic core_cause_pending_6,
  output logic cpu_nmi
);
  import sgc_pkg::*;

  generate
    if (NREQ < 2 || NREQ > 32) begin : g_bad
      $error("NREQ must lie between 2 and 32");
    end
  endgenerate

  // merge write data by byte lane, only writable bits change
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be, input logic [31:0] msk);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & msk;
    return (old & ~m) | (wd & m);
  endfunction

  // lowest set request wins; index 0 is the controller itself
  function automatic logic [NREQ-1:0] first_req(input logic [NREQ-1:0] r);
    logic [NREQ-1:0] g;
    g = '0;
    for (int i = NREQ - 1; i >= 0; i--) begin
      if (r[i]) begin
        g = '0;
        g[i] = 1'b1;
      end
    end
    return g;
  endfunction

  logic [31:0] gmr_r, gmr_nxt;
  logic [2:0] gsr_r, gsr_nxt;
  logic strap_done_r, strap_done_nxt;
  logic [4:0] isr_r, isr_nxt, imr_r, imr_nxt;
  logic [5:0] nsr_r, nsr_nxt, ner_r, ner_nxt;
  logic ack_r, ack_nxt, derr_r, derr_nxt, cold_r, cold_nxt;
  logic [31:0] rdata_r, rdata_nxt, hsw_r, hsw_nxt, msw_r, msw_nxt;
  logic [NREQ-1:0] grant_r, grant_nxt;
  logic [4:0] isr_set;
  logic [5:0] nsr_set;
  logic acc, rd, wr, mapped, burst_acc, rsv_acc, isr_clr, nsr_clr;

  // event sources into the two pending registers
  always_comb begin
    isr_set = '0;
    isr_set[`SGC_ISR_TM0] = irq_src.timer0;
    isr_set[`SGC_ISR_TM1] = irq_src.timer1;
    isr_set[`SGC_ISR_UART] = irq_src.uart_rx_full | irq_src.uart_tx_empty |
                             irq_src.uart_line_stat | irq_src.uart_modem_stat; // [RULE15]
    isr_set[`SGC_ISR_EXT] = ~ext_irq_pin_n; // [RULE14]
    isr_set[`SGC_ISR_WU] = irq_src.usb_wakeup | irq_src.eth_wakeup; // [RULE17]
    nsr_set = '0;
    nsr_set[`SGC_NSR_IR] = burst_acc; // [RULE20]
    nsr_set[`SGC_NSR_EXT] = ~ext_nonmaskable_pin_n;
    nsr_set[`SGC_NSR_MA] = err_src.mem_reserved | err_src.mem_out_of_range |
                           err_src.rom_narrow | err_src.rom_burst_write; // [RULE21]
    nsr_set[`SGC_NSR_IT] = err_src.onchip_timeout;
    nsr_set[`SGC_NSR_IB] = err_src.onchip_reserved; // [RULE22]
    nsr_set[`SGC_NSR_CB] = err_src.cpu_illegal_cmd | err_src.cpu_illegal_align |
                           err_src.cpu_illegal_burst | rsv_acc; // [RULE22]
  end

  // access decode; bursts are refused and flagged, never performed
  always_comb begin
    acc = reg_req.valid;
    burst_acc = acc & reg_req.burst;
    rd = acc & ~reg_req.burst & ~reg_req.write;
    wr = acc & ~reg_req.burst & reg_req.write;
    if (reg_req.addr == `SGC_OFF_GMR) begin
      mapped = 1'b1;
    end else if (reg_req.addr == `SGC_OFF_GSR) begin
      mapped = 1'b1;
    end else if (reg_req.addr == `SGC_OFF_ISR) begin
      mapped = 1'b1;
    end else if (reg_req.addr == `SGC_OFF_IMR) begin
      mapped = 1'b1;
    end else if (reg_req.addr == `SGC_OFF_NSR) begin
      mapped = 1'b1;
    end else if (reg_req.addr == `SGC_OFF_NER) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
    rsv_acc = (rd | wr) & ~mapped;
    isr_clr = rd & (reg_req.addr == `SGC_OFF_ISR) & reg_req.be[0]; // [RULE16]
    nsr_clr = rd & (reg_req.addr == `SGC_OFF_NSR) & reg_req.be[0]; // [RULE23]
  end

  // register file next state; a new event beats a same-cycle clearing read
  always_comb begin
    gmr_nxt = gmr_r;
    imr_nxt = imr_r;
    ner_nxt = ner_r;
    cold_nxt = 1'b0;
    ack_nxt = acc;
    derr_nxt = rd & ~mapped;
    rdata_nxt = rdata_r;
    isr_nxt = (isr_r & ~{5{isr_clr}}) | isr_set; // [RULE13]
    nsr_nxt = (nsr_r & ~{6{nsr_clr}}) | nsr_set; // [RULE23]
    if (wr) begin
      if (reg_req.addr == `SGC_OFF_GMR) begin
        gmr_nxt = lane_merge(gmr_r, reg_req.wdata, reg_req.be, `SGC_GMR_WMASK); // [RULE1]
        cold_nxt = reg_req.be[0] & reg_req.wdata[`SGC_GMR_COLD]; // [RULE4]
      end else if (reg_req.addr == `SGC_OFF_IMR) begin
        imr_nxt = reg_req.be[0] ? reg_req.wdata[4:0] : imr_r; // [RULE19]
      end else if (reg_req.addr == `SGC_OFF_NER) begin
        ner_nxt = reg_req.be[0] ? reg_req.wdata[5:0] : ner_r; // [RULE24]
      end
    end
    if (rd) begin
      if (reg_req.addr == `SGC_OFF_GMR) begin
        rdata_nxt = gmr_r & `SGC_GMR_WMASK; // [RULE1]
      end else if (reg_req.addr == `SGC_OFF_GSR) begin
        rdata_nxt = {29'h0, gsr_r}; // [RULE11] [RULE12]
      end else if (reg_req.addr == `SGC_OFF_ISR) begin
        rdata_nxt = {27'h0, isr_r}; // [RULE14]
      end else if (reg_req.addr == `SGC_OFF_IMR) begin
        rdata_nxt = {27'h0, imr_r};
      end else if (reg_req.addr == `SGC_OFF_NSR) begin
        rdata_nxt = {26'h0, nsr_r}; // [RULE20]
      end else if (reg_req.addr == `SGC_OFF_NER) begin
        rdata_nxt = {26'h0, ner_r};
      end else begin
        rdata_nxt = 32'h0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      gmr_r <= `SGC_GMR_RST;
      imr_r <= `SGC_IRQ_RST;
      isr_r <= `SGC_IRQ_RST;
      ner_r <= `SGC_ERR_RST;
      nsr_r <= `SGC_ERR_RST;
      cold_r <= 1'b0;
      ack_r <= 1'b0;
      derr_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      gmr_r <= gmr_nxt;
      imr_r <= imr_nxt;
      isr_r <= isr_nxt;
      ner_r <= ner_nxt;
      nsr_r <= nsr_nxt;
      cold_r <= cold_nxt;
      ack_r <= ack_nxt;
      derr_r <= derr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // straps are caught once, on the first edge after reset release
  always_comb begin
    strap_done_nxt = 1'b1;
    gsr_nxt = gsr_r;
    if (!strap_done_r) begin
      gsr_nxt[`SGC_GSR_ENDC] = endian_conv_strap; // [RULE12]
      gsr_nxt[`SGC_GSR_SPEED] = cpu_speed_strap; // [RULE11]
      gsr_nxt[`SGC_GSR_CISA] = compressed_isa_strap; // [RULE12]
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      strap_done_r <= 1'b0;
      gsr_r <= 3'h0;
    end else begin
      strap_done_r <= strap_done_nxt;
      gsr_r <= gsr_nxt;
    end
  end

  // swap converters act only in address swap mode and in their own region
  always_comb begin
    hsw_nxt = hsw_in.data;
    if (gmr_r[`SGC_GMR_HSW] && hsw_in.in_target && hsw_in.addr_swap) begin // [RULE7]
      case (hsw_in.size)
        SGC_SZ_1B: hsw_nxt = {hsw_in.data[7:0], hsw_in.data[15:8],
                              hsw_in.data[23:16], hsw_in.data[31:24]}; // [RULE8]
        SGC_SZ_2B: hsw_nxt = {hsw_in.data[15:0], hsw_in.data[31:16]}; // [RULE8]
        SGC_SZ_3B: begin
          if (hsw_in.off == 2'h0) begin
            hsw_nxt = {hsw_in.data[7:0], hsw_in.data[31:8]}; // [RULE9]
          end else begin
            hsw_nxt = {hsw_in.data[23:0], hsw_in.data[31:24]}; // [RULE9]
          end
        end
        default: hsw_nxt = hsw_in.data; // whole words pass
      endcase
    end
    msw_nxt = msw_in.data;
    if (gmr_r[`SGC_GMR_MSW] && msw_in.via_slave && msw_in.addr_swap) begin
      msw_nxt = {msw_in.data[7:0], msw_in.data[15:8],
                 msw_in.data[23:16], msw_in.data[31:24]}; // [RULE10]
    end
    // while disabled only the controller may hold the on-chip bus
    if (gmr_r[`SGC_GMR_ARB]) begin
      grant_nxt = first_req(bus_req); // [RULE2]
    end else begin
      grant_nxt = first_req(bus_req & NREQ'(1)); // [RULE2] [RULE3]
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      hsw_r <= 32'h0;
      msw_r <= 32'h0;
      grant_r <= '0;
    end else begin
      hsw_r <= hsw_nxt;
      msw_r <= msw_nxt;
      grant_r <= grant_nxt;
    end
  end

  // outputs; interrupt lines are levels that fall after the clearing read
  assign reg_ack = ack_r;
  assign reg_rdata = rdata_r;
  assign reg_data_err = derr_r;
  assign hsw_out = hsw_r;
  assign msw_out = msw_r;
  assign bus_grant = grant_r;
  assign prefetch_disable = gmr_r[`SGC_GMR_PFD]; // [RULE5]
  assign uart_clock_source_sel = gmr_r[`SGC_GMR_UCS]; // [RULE6]
  assign cold_reset_request = cold_r;
  assign cpu_int = |(isr_r[3:0] & imr_r[3:0]); // [RULE19] [RULE25]
  assign core_cause_pending_6 = isr_r[`SGC_ISR_WU] & imr_r[`SGC_ISR_WU]; // [RULE18]
  assign cpu_nmi = |(nsr_r & ner_r); // [RULE24]

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_gmr_zero;
    rd && reg_req.addr == `SGC_OFF_GMR |=> (reg_rdata & ~`SGC_GMR_WMASK) == 32'h0;
  endproperty
  a_gmr_zero: assert property (p_gmr_zero) else $error("mode reserved bits nonzero"); // [RULE1]

  property p_arb_lock;
    !gmr_r[`SGC_GMR_ARB] |=> bus_grant[NREQ-1:1] == '0;
  endproperty
  a_arb_lock: assert property (p_arb_lock) else $error("grant while arbiter off"); // [RULE2]

  property p_cold;
    wr && reg_req.addr == `SGC_OFF_GMR && reg_req.be[0] && reg_req.wdata[0]
      |=> cold_reset_request ##1 !cold_reset_request;
  endproperty
  a_cold: assert property (p_cold) else $error("cold reset pulse wrong"); // [RULE4]

  property p_pfd;
    wr && reg_req.addr == `SGC_OFF_GMR && reg_req.be[0]
      |=> prefetch_disable == $past(reg_req.wdata[2]);
  endproperty
  a_pfd: assert property (p_pfd) else $error("prefetch disable not written"); // [RULE5]

  property p_hsw_half;
    gmr_r[`SGC_GMR_HSW] && hsw_in.in_target && hsw_in.addr_swap && hsw_in.size == SGC_SZ_2B
      |=> hsw_out == {$past(hsw_in.data[15:0]), $past(hsw_in.data[31:16])};
  endproperty
  a_hsw_half: assert property (p_hsw_half) else $error("halfword swap wrong"); // [RULE8]

  property p_msw;
    !(gmr_r[`SGC_GMR_MSW] && msw_in.via_slave && msw_in.addr_swap)
      |=> msw_out == $past(msw_in.data);
  endproperty
  a_msw: assert property (p_msw) else $error("slave path altered while off"); // [RULE10]

  property p_isr_clear;
    isr_clr && isr_set == 5'h0 |=> isr_r == 5'h0 && !cpu_int;
  endproperty
  a_isr_clear: assert property (p_isr_clear) else $error("clearing read failed"); // [RULE13]

  property p_timer_wins;
    irq_src.timer0 |=> isr_r[`SGC_ISR_TM0];
  endproperty
  a_timer_wins: assert property (p_timer_wins) else $error("timer event lost"); // [RULE13]

  property p_nsr_keep;
    rd && reg_req.addr == `SGC_OFF_NSR && !reg_req.be[0] |=> nsr_r >= $past(nsr_r);
  endproperty
  a_nsr_keep: assert property (p_nsr_keep) else $error("error bits lost"); // [RULE23]

  property p_nmi;
    ner_r[`SGC_NSR_EXT] && !ext_nonmaskable_pin_n |=> cpu_nmi;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi missing"); // [RULE24]

  property p_burst;
    burst_acc |=> nsr_r[`SGC_NSR_IR];
  endproperty
  a_burst: assert property (p_burst) else $error("burst not flagged"); // [RULE20]

  property p_uart;
    irq_src.uart_rx_full || irq_src.uart_tx_empty || irq_src.uart_line_stat
      || irq_src.uart_modem_stat |=> isr_r[`SGC_ISR_UART];
  endproperty
  a_uart: assert property (p_uart) else $error("uart cause lost"); // [RULE15]

  property p_wakeup;
    irq_src.usb_wakeup || irq_src.eth_wakeup |=> isr_r[`SGC_ISR_WU];
  endproperty
  a_wakeup: assert property (p_wakeup) else $error("wakeup request lost"); // [RULE17]

  property p_unmask_wr;
    wr && reg_req.addr == `SGC_OFF_IMR && reg_req.be[0]
      |=> imr_r == $past(reg_req.wdata[4:0]);
  endproperty
  a_unmask_wr: assert property (p_unmask_wr) else $error("unmask not written"); // [RULE19]

  // an unmasked pending bit keeps the line up until a clearing read or a new mask
  property p_int_level;
    cpu_int && !isr_clr && !(wr && reg_req.addr == `SGC_OFF_IMR) |=> cpu_int;
  endproperty
  a_int_level: assert property (p_int_level) else $error("interrupt dropped"); // [RULE25]

  c_int: cover property (isr_r[0] && imr_r[0] ##[1:20] isr_clr);
  c_swap3: cover property (gmr_r[`SGC_GMR_HSW] && hsw_in.size == SGC_SZ_3B && hsw_in.addr_swap);
  c_grant: cover property (gmr_r[`SGC_GMR_ARB] && bus_grant[NREQ-1]);
  c_nmi: cover property (cpu_nmi ##1 nsr_clr);
endmodule
`default_nettype wire

//--- tb/sgc_cpu_model.sv
// cpu system bus model that issues one register access at a time
`timescale 1ns/1ps
`default_nettype none
module sgc_cpu_model (
  input wire logic clock,
  output sgc_pkg::sgc_regreq_t reg_req,
  input wire logic reg_ack,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_data_err
);
  import sgc_pkg::*;
  initial reg_req = '0;
  // valid is a one-cycle pulse; the idle bus shows inverted junk, not the last access
  // be[0] must be set by the caller for a clearing read
  task automatic access(input logic w, input logic b, input logic [7:0] a,
      input logic [3:0] be, input logic [31:0] d, output logic ok);
    @(posedge clock);
    #1 reg_req = '{1'b1, w, b, a, be, d};
    @(posedge clock);
    #1 reg_req = {1'b0, ~reg_req[$bits(sgc_regreq_t)-2:0]};
    ok = reg_ack;
  endtask
endmodule
`default_nettype wire

//--- tb/sgc_regs_tb.sv
// self-checking bench for the general register bank
`timescale 1ns/1ps
`default_nettype none
`include "sgc_params.svh"
module sgc_regs_tb;
  import sgc_pkg::*;
  logic clock, srst, reg_ack, reg_data_err, prefetch_disable, uart_clock_source_sel, ok;
  logic cold_reset_request, ext_irq_pin_n, ext_nonmaskable_pin_n, cpu_int, cpu_nmi;
  logic core_cause_pending_6, endian_conv_strap, cpu_speed_strap, compressed_isa_strap;
  logic rd_ack;
  logic [31:0] reg_rdata, hsw_out, msw_out, v;
  logic [3:0] bus_req, bus_grant;
  sgc_regreq_t reg_req;
  sgc_hswap_t hsw_in;
  sgc_mswap_t msw_in;
  sgc_irq_src_t irq_src;
  sgc_err_src_t err_src;
  logic [32:0] exp_q[$];
  integer seed;
  int n_errors, checked, n_cold;
  logic [7:0] offs[5] = '{`SGC_OFF_GMR, `SGC_OFF_ISR, `SGC_OFF_IMR, `SGC_OFF_NSR, `SGC_OFF_NER};
  int pm[9] = '{0, 1, 2, 2, 2, 2, 4, 4, 3};
  int nm[10] = '{3, 3, 3, 3, 0, 0, 0, 1, 2, 4};

  sgc_regs #(.NREQ(4)) dut (.clock(clock), .srst(srst), .reg_req(reg_req), .reg_ack(reg_ack),
    .reg_rdata(reg_rdata), .reg_data_err(reg_data_err), .hsw_in(hsw_in), .hsw_out(hsw_out),
    .msw_in(msw_in), .msw_out(msw_out), .bus_req(bus_req), .bus_grant(bus_grant),
    .prefetch_disable(prefetch_disable), .uart_clock_source_sel(uart_clock_source_sel),
    .cold_reset_request(cold_reset_request), .endian_conv_strap(endian_conv_strap),
    .cpu_speed_strap(cpu_speed_strap), .compressed_isa_strap(compressed_isa_strap),
    .irq_src(irq_src), .ext_irq_pin_n(ext_irq_pin_n),
    .ext_nonmaskable_pin_n(ext_nonmaskable_pin_n), .err_src(err_src), .cpu_int(cpu_int),
    .core_cause_pending_6(core_cause_pending_6), .cpu_nmi(cpu_nmi));
  sgc_cpu_model cpu (.clock(clock), .reg_req(reg_req), .reg_ack(reg_ack),
    .reg_rdata(reg_rdata), .reg_data_err(reg_data_err));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic results();
    $display("counts: %0d checked, %0d wrong", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // a missing ack ends the run at once, since nothing after it can be trusted
  task automatic acc(input logic w, input logic b, input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] d);
    cpu.access(w, b, a, be, d, ok);
    if (ok !== 1'b1) begin
      n_errors++;
      results();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [3:0] be, input logic [32:0] e);
    exp_q.push_back(e);
    acc(1'b0, 1'b0, a, be, 32'h0);
  endtask

  // byte lane reversal, as both converters define it
  function automatic logic [31:0] brev(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  function automatic logic [31:0] hexp(sgc_hswap_t h, logic en);
    if (!(en && h.in_target && h.addr_swap)) return h.data;
    case (h.size)
      SGC_SZ_1B: return brev(h.data);
      SGC_SZ_2B: return {h.data[15:0], h.data[31:16]};
      SGC_SZ_3B: begin
        if (h.off == 2'h0) return {h.data[7:0], h.data[31:8]};
        return {h.data[23:0], h.data[31:24]};
      end
      default: return h.data;
    endcase
  endfunction

  // reads are judged at the falling edge, well away from the registered update
  always @(posedge clock) begin
    rd_ack <= reg_req.valid & ~reg_req.write;
  end
  always @(negedge clock) begin
    if (rd_ack === 1'b1 && exp_q.size() > 0) begin
      chk({reg_ack, reg_data_err, reg_rdata}, {1'b1, exp_q.pop_front()});
    end
    if (cold_reset_request === 1'b1) n_cold++;
  end

  initial begin
    seed = 32'h24d0;
    n_errors = 0;
    checked = 0;
    n_cold = 0;
    srst = 1'b1;
    hsw_in = '0;
    msw_in = '0;
    bus_req = 4'h0;
    irq_src = '0;
    err_src = '0;
    ext_irq_pin_n = 1'b1;
    ext_nonmaskable_pin_n = 1'b1;
    {compressed_isa_strap, cpu_speed_strap, endian_conv_strap} = 3'h5;
    repeat (12) @(posedge clock);
    #1 srst = 1'b0;
    tick(2);
    chk(34'({cpu_int, cpu_nmi, core_cause_pending_6, bus_grant}), 34'h0);
    foreach (offs[i]) rd(offs[i], 4'hf, 33'h0);
    rd(`SGC_OFF_GSR, 4'hf, 33'h5);
    $display("test reset done");
    v = $random(seed);
    acc(1'b1, 1'b0, `SGC_OFF_GMR, 4'hf, v | 32'h1);
    rd(`SGC_OFF_GMR, 4'hf, {1'b0, v & 32'h30e});
    chk(34'({prefetch_disable, uart_clock_source_sel}), 34'({v[2], v[3]}));
    acc(1'b1, 1'b0, `SGC_OFF_GMR, 4'hf, 32'h0);
    tick(1);
    chk(34'(n_cold), 34'h1);
    $display("test mode done");
    bus_req = 4'he;
    tick(2);
    chk(34'(bus_grant), 34'h0);
    bus_req = 4'hf;
    tick(2);
    chk(34'(bus_grant), 34'h1);
    acc(1'b1, 1'b0, `SGC_OFF_GMR, 4'hf, 32'h302);
    bus_req = 4'hc;
    tick(2);
    chk(34'(bus_grant), 34'h4);
    bus_req = 4'h8;
    tick(2);
    chk(34'(bus_grant), 34'h8);
    $display("test arbiter done");
    // first pass with both swaps on, second with them off
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 64; i++) begin
        hsw_in = '{32'($random(seed)), sgc_size_t'(i[1:0]), i[3:2], i[4], i[5]};
        msw_in = '{32'($random(seed)), i[4], i[5]};
        tick(1);
        chk(34'(hsw_out), 34'(hexp(hsw_in, m == 0)));
        v = (m == 0 && i[5:4] == 2'h3) ? brev(msw_in.data) : msw_in.data;
        chk(34'(msw_out), 34'(v));
      end
      acc(1'b1, 1'b0, `SGC_OFF_GMR, 4'hf, 32'h2);
    end
    $display("test swap done");
    acc(1'b1, 1'b0, `SGC_OFF_IMR, 4'hf, 32'h1f);
    for (int j = 0; j < 9; j++) begin
      {irq_src, ext_irq_pin_n} = (9'h100 >> j) ^ 9'h1;
      tick(1);
      {irq_src, ext_irq_pin_n} = 9'h1;
      tick(1);
      chk(34'({cpu_int, core_cause_pending_6}),
          34'({pm[j] != 4, pm[j] == 4}));
      rd(`SGC_OFF_ISR, 4'he, 33'(1 << pm[j]));
      rd(`SGC_OFF_ISR, 4'h1, 33'(1 << pm[j]));
      rd(`SGC_OFF_ISR, 4'hf, 33'h0);
      chk(34'({cpu_int, core_cause_pending_6}), 34'h0);
    end
    acc(1'b1, 1'b0, `SGC_OFF_IMR, 4'hf, 32'h0);
    irq_src = 8'h80;
    tick(1);
    irq_src = '0;
    tick(1);
    chk(34'(cpu_int), 34'h0);
    rd(`SGC_OFF_ISR, 4'hf, 33'h1);
    $display("test interrupt done");
    acc(1'b1, 1'b0, `SGC_OFF_NER, 4'hf, 32'h3f);
    for (int j = 0; j < 10; j++) begin
      {err_src, ext_nonmaskable_pin_n} = (10'h200 >> j) ^ 10'h1;
      tick(1);
      {err_src, ext_nonmaskable_pin_n} = 10'h1;
      tick(1);
      chk(34'(cpu_nmi), 34'h1);
      rd(`SGC_OFF_NSR, 4'he, 33'(1 << nm[j]));
      rd(`SGC_OFF_NSR, 4'h1, 33'(1 << nm[j]));
      rd(`SGC_OFF_NSR, 4'hf, 33'h0);
      chk(34'(cpu_nmi), 34'h0);
    end
    acc(1'b1, 1'b1, `SGC_OFF_GMR, 4'hf, 32'h30e);
    rd(`SGC_OFF_GMR, 4'hf, 33'h2);
    rd(8'h40, 4'hf, {1'b1, 32'h0});
    rd(`SGC_OFF_NSR, 4'h1, 33'h21);
    // only lane 1 is enabled, so the swap bits change and no cold reset starts
    acc(1'b1, 1'b0, `SGC_OFF_GMR, 4'h2, 32'hffffffff);
    rd(`SGC_OFF_GMR, 4'hf, 33'h302);
    chk(34'(n_cold), 34'h1);
    $display("test error done");
    tick(2);
    results();
  end
endmodule
`default_nettype wire
